// *** inc/hmw_defs.vh ***
`ifndef HMW_DEFS_VH
`define HMW_DEFS_VH
// ===========================================
// cycle codes
`define HMW_START_WRITE 4'hE
`define HMW_SIZE_BYTE 4'h0
`define HMW_SYNC_READY 4'h0
`define HMW_ALL_ONES 4'hF
`define HMW_ABORT_CODE 4'hF
// ===========================================
// field positions and counts
`define HMW_ADDR_NIBBLES 3'h7
`define HMW_TARGET_BIT 22
// ===========================================
// reset values
`define HMW_ADDR_RESET 28'h0000000
`define HMW_DATA_RESET 8'h00
`define HMW_NIB_RESET 4'h0
`define HMW_PIN_RESET 9'h1FF
`endif

// *** src/hmw_pin_sync.v ***
// ===========================================
// two-stage synchroniser for the bus pins; only stage two is read
`include "hmw_defs.vh"
module hmw_pin_sync (
    input wire clk_i,
    input wire srst_i,
    input wire [8:0] d_i,
    output wire [8:0] q_o
);
    reg [8:0] meta_q;
    reg [8:0] sync_q;
    always @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= `HMW_PIN_RESET;
            sync_q <= `HMW_PIN_RESET;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end
    assign q_o = sync_q;
endmodule

// *** src/hmw_write_cycle.v ***
// Summary of operation
// - start code 1110 with frame opens a memory write cycle
// - second nibble selects device; only a match with straps responds
// - clocks 3 to 9 carry a 28-bit address in seven nibbles
// - address nibbles arrive most significant first, shifted in
// - clock 10 size nibble; only 0000 single byte is supported
// - clocks 11 and 12 carry the byte, low nibble first
// - clock 14 bus floats, then the device takes over
// - device drives ready sync 0000 in clock 15; the synchroniser lag puts it in clock 17 here
// - device drives 1111 in clock 16 then releases the bus; here 1111 lands in clock 18
// - every nibble is sampled on the rising clock edge
// - address bit 22 high targets the array, low the registers
// - frame again mid-cycle aborts; bus stays released until code 1111
`include "hmw_defs.vh"
module hmw_write_cycle (
    input wire clk_i,
    input wire srst_i,
    input wire [3:0] hub_nibble_bus_i,
    input wire cycle_frame_pin_n_i,
    input wire [3:0] strap_identity_pins_i,
    output reg [3:0] hub_nibble_bus_o,
    output reg hub_nibble_bus_oe_o,
    output reg [27:0] wr_addr_o,
    output reg [7:0] wr_data_o,
    output reg wr_array_sel_o,
    output reg wr_strobe_o
);
    // ===========================================
    // states
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_SEL = 4'h1;
    localparam [3:0] ST_ADDR = 4'h2;
    localparam [3:0] ST_SIZE = 4'h3;
    localparam [3:0] ST_DLO = 4'h4;
    localparam [3:0] ST_DHI = 4'h5;
    localparam [3:0] ST_TURN_FIRST = 4'h6;
    localparam [3:0] ST_TURN_SECOND = 4'h7;
    localparam [3:0] ST_SYNC = 4'h8;
    localparam [3:0] ST_TARD = 4'h9;
    localparam [3:0] ST_ABORT = 4'hA;

    // ===========================================
    // shared nibble decode
    // one compare serves start, select, size and abort, so all decode alike
    function match_nib;
        input [3:0] a;
        input [3:0] b;
        begin
            match_nib = (a == b);
        end
    endfunction

    // ===========================================
    // internal signals
    wire [8:0] pins_s;
    wire [3:0] nib;
    wire [3:0] strap_s;
    wire frame;
    wire start_hit;
    wire abort_hit;
    wire in_cycle;
    wire accept;
    wire hand_off;
    wire [27:0] addr_shift;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [2:0] cnt_q;
    reg sel_q;
    reg size_ok_q;
    reg [27:0] addr_q;
    reg [3:0] dlo_q;
    reg drive_en_d;
    reg [3:0] drive_val_d;

    // ===========================================
    // pin synchronisation
    // the straps are sampled too; a strap that moves while a cycle runs
    // would otherwise reach the select compare half-settled
    // the pins reach the state machine two clocks late; every response keeps that lag
    hmw_pin_sync u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i({cycle_frame_pin_n_i, strap_identity_pins_i, hub_nibble_bus_i}),
        .q_o(pins_s)
    );
    assign nib = pins_s[3:0];
    assign strap_s = pins_s[7:4];
    assign frame = ~pins_s[8];

    // ===========================================
    // field decode
    assign start_hit = frame && match_nib(nib, `HMW_START_WRITE);
    assign abort_hit = match_nib(nib, `HMW_ABORT_CODE);
    // a start frame may stretch over the select clock, so that clock never aborts
    assign in_cycle = (state_q != ST_IDLE) && (state_q != ST_SEL) && (state_q != ST_ABORT);
    // ready sync claims acceptance, so an unsupported size is not answered
    assign accept = sel_q && size_ok_q;
    assign hand_off = (state_q == ST_DHI) && (state_d == ST_TURN_FIRST) && accept;

    // ===========================================
    // address shift path, one nibble slot per stage
    // slot six carries address bits 27 to 24 once all seven have passed
    genvar g;
    generate
        for (g = 1; g < `HMW_ADDR_NIBBLES; g = g + 1) begin : g_shift
            assign addr_shift[g*4+3:g*4] = addr_q[g*4-1:g*4-4];
        end
    endgenerate
    // the newest nibble enters at the bottom, so the first one ends up on top
    assign addr_shift[3:0] = nib;

    // ===========================================
    // next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_hit) state_d = ST_SEL;
            end
            ST_SEL: state_d = ST_ADDR;
            ST_ADDR: begin
                // the last nibble shifts in on the same edge that leaves this state
                if (cnt_q == `HMW_ADDR_NIBBLES - 3'h1) state_d = ST_SIZE;
            end
            ST_SIZE: state_d = ST_DLO;
            ST_DLO: state_d = ST_DHI;
            ST_DHI: state_d = ST_TURN_FIRST;
            ST_TURN_FIRST: state_d = ST_TURN_SECOND;
            ST_TURN_SECOND: state_d = ST_SYNC;
            ST_SYNC: state_d = ST_TARD;
            ST_TARD: state_d = ST_IDLE;
            ST_ABORT: begin
                if (abort_hit) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        // a frame inside the cycle terminates it
        if (frame && in_cycle) begin
            state_d = ST_ABORT;
        end
    end

    // ===========================================
    // sequencing and field capture
    // the counter restarts in the select clock so a cut cycle leaves no stale count
    always @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            sel_q <= 1'b0;
            size_ok_q <= 1'b0;
            addr_q <= `HMW_ADDR_RESET;
            dlo_q <= `HMW_NIB_RESET;
        end else begin
            state_q <= state_d;
            if (state_q == ST_SEL) begin
                sel_q <= match_nib(nib, strap_s);
                cnt_q <= 3'h0;
            end
            if (state_q == ST_ADDR) begin
                addr_q <= addr_shift;
                cnt_q <= cnt_q + 3'h1;
            end
            if (state_q == ST_SIZE) begin
                size_ok_q <= match_nib(nib, `HMW_SIZE_BYTE);
            end
            if (state_q == ST_DLO) begin
                dlo_q <= nib;
            end
        end
    end

    // ===========================================
    // write port toward the array and register space
    // address and data stand until the next accepted write
    // the strobe is a single clock pulse; consumers must latch on it
    always @(posedge clk_i) begin
        if (srst_i) begin
            wr_addr_o <= `HMW_ADDR_RESET;
            wr_data_o <= `HMW_DATA_RESET;
            wr_array_sel_o <= 1'b0;
            wr_strobe_o <= 1'b0;
        end else begin
            wr_strobe_o <= hand_off;
            if (hand_off) begin
                wr_data_o <= {nib, dlo_q};
                wr_addr_o <= addr_q;
                wr_array_sel_o <= addr_q[`HMW_TARGET_BIT];
            end
        end
    end

    // ===========================================
    // bus drive: sync in the first owned clock, ones in the second
    // value and enable are registered together, so the pads never
    // see the enable ahead of the value
    // sync and ones are the only values this side ever puts on the bus
    always @* begin
        drive_en_d = 1'b0;
        drive_val_d = `HMW_ALL_ONES;
        if (accept && state_d == ST_SYNC) begin
            drive_en_d = 1'b1;
            drive_val_d = `HMW_SYNC_READY;
        end
        if (accept && state_d == ST_TARD) begin
            drive_en_d = 1'b1;
            drive_val_d = `HMW_ALL_ONES;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            hub_nibble_bus_o <= `HMW_ALL_ONES;
            hub_nibble_bus_oe_o <= 1'b0;
        end else begin
            hub_nibble_bus_o <= drive_val_d;
            hub_nibble_bus_oe_o <= drive_en_d;
        end
    end
endmodule

// *** bench/hmw_write_cycle_properties.sv ***
module hmw_checker (
    input wire clk_i, input wire srst_i, input wire [3:0] hub_nibble_bus_i,
    input wire cycle_frame_pin_n_i, input wire [3:0] strap_identity_pins_i,
    input wire [3:0] hub_nibble_bus_o, input wire hub_nibble_bus_oe_o,
    input wire [27:0] wr_addr_o, input wire [7:0] wr_data_o,
    input wire wr_array_sel_o, input wire wr_strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire s = wr_strobe_o;
    wire e = hub_nibble_bus_oe_o;
    wire [3:0] o = hub_nibble_bus_o;
    wire [3:0] b = hub_nibble_bus_i;
    // ===========================================
    // strobe lands 14 clocks after the start nibble on the pins
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_sync; s |-> ##2 (e && o == 4'h0); endproperty
    a_sync: assert property (p_sync) else $error("no ready sync");
    property p_rel; s |-> ##3 (e && o == 4'hF) ##1 !e; endproperty
    a_rel: assert property (p_rel) else $error("bad release");
    property p_own; $rose(e) |-> $past(s, 2); endproperty
    a_own: assert property (p_own) else $error("drive without write");
    property p_start; s |-> $past(b, 14) == 4'hE && !$past(cycle_frame_pin_n_i, 14); endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_id; s |-> $past(b, 13) == strap_identity_pins_i; endproperty
    a_id: assert property (p_id) else $error("wrong select");
    property p_addr; s |-> wr_addr_o[3:0] == $past(b, 6) && wr_addr_o[27:24] == $past(b, 12); endproperty
    a_addr: assert property (p_addr) else $error("bad address");
    property p_size; s |-> $past(b, 5) == 4'h0; endproperty
    a_size: assert property (p_size) else $error("bad size");
    property p_data; s |-> wr_data_o == {$past(b, 3), $past(b, 4)}; endproperty
    a_data: assert property (p_data) else $error("bad data");
    property p_tgt; s |-> wr_array_sel_o == wr_addr_o[22]; endproperty
    a_tgt: assert property (p_tgt) else $error("bad target");
    c_arr: cover property (s && wr_array_sel_o);
    c_reg: cover property (s && !wr_array_sel_o);
    c_rel: cover property ($fell(e));
endmodule
bind hmw_write_cycle hmw_checker u_chk (.*);

// *** bench/hmw_host.sv ***
module hmw_host (
    input wire logic clk_i,
    output logic [3:0] nib_o,
    output logic oe_o,
    output logic frame_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        nib_o = 4'hF;
        oe_o = 1'b1;
        frame_n_o = 1'b1;
    end
    task automatic send(input logic [3:0] n, input logic f);
        @(negedge clk_i);
        nib_o = n;
        frame_n_o = f;
    endtask
    task automatic wr(input logic [3:0] id, input logic [27:0] a, input logic [7:0] d,
                      input logic [3:0] sz);
        send(4'hE, 1'b0);
        send(id, 1'b1);
        for (int i = 6; i >= 0; i--) begin
            send(a[i*4+:4], 1'b1);
        end
        send(sz, 1'b1);
        send(d[3:0], 1'b1);
        send(d[7:4], 1'b1);
        send(4'hF, 1'b1);
        send(4'hF, 1'b1);
        oe_o = 1'b0;
        // the device answers two clocks late behind its synchroniser
        repeat (5) @(negedge clk_i);
        oe_o = 1'b1;
    endtask
endmodule

// *** bench/test_hub_memory_write_cycle.sv ***
module test_hub_memory_write_cycle;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] straps = 4'h5;
    wire [3:0] h_nib, d_nib;
    wire h_oe, d_oe, fr_n, stb, sel;
    wire [27:0] ad;
    wire [7:0] da;
    // released bus floats up to all ones through the pull-ups
    wire [3:0] bus = d_oe ? d_nib : (h_oe ? h_nib : 4'hF);
    int n_mismatch = 0, n_compared = 0, n_stb = 0, n_oe = 0, n_sync = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        n_stb += (stb === 1'b1);
        n_oe += (d_oe === 1'b1);
        n_sync += (d_oe === 1'b1 && d_nib === 4'h0);
    end
    hmw_host u_host (.clk_i(clk), .nib_o(h_nib), .oe_o(h_oe), .frame_n_o(fr_n));
    hmw_write_cycle u_dut (.clk_i(clk), .srst_i(srst), .hub_nibble_bus_i(bus),
        .cycle_frame_pin_n_i(fr_n), .strap_identity_pins_i(straps), .hub_nibble_bus_o(d_nib),
        .hub_nibble_bus_oe_o(d_oe), .wr_addr_o(ad), .wr_data_o(da), .wr_array_sel_o(sel),
        .wr_strobe_o(stb));
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic run(input logic [3:0] id, input logic [27:0] a, input logic [7:0] d,
                       input logic [3:0] sz, input int ok);
        n_stb = 0;
        n_oe = 0;
        n_sync = 0;
        u_host.wr(id, a, d, sz);
        repeat (3) @(negedge clk);
        chk("strobes", ok, n_stb);
        chk("drive clocks", 2 * ok, n_oe);
        chk("ready sync", ok, n_sync);
        if (ok == 1) begin
            chk("addr", a, ad);
            chk("data", d, da);
            chk("target", a[22], sel);
        end
    endtask
    task automatic s_array; run(4'h5, 28'hA4BC3D2, 8'h96, 4'h0, 1); endtask
    task automatic s_regs; run(4'h5, 28'h5B3C4E1, 8'h69, 4'h0, 1); endtask
    task automatic s_other; run(4'h6, 28'hFFFFFFF, 8'hFF, 4'h0, 0); endtask
    task automatic s_size; run(4'h5, 28'h0400000, 8'h11, 4'h1, 0); endtask
    task automatic s_ids;
        straps = 4'h0;
        run(4'h0, 28'h0000001, 8'h80, 4'h0, 1);
        straps = 4'hF;
        run(4'hF, 28'hFFFFFFF, 8'h01, 4'h0, 1);
        straps = 4'h5;
    endtask
    task automatic s_abort;
        n_stb = 0;
        n_oe = 0;
        u_host.send(4'hE, 1'b0);
        u_host.send(4'h5, 1'b1);
        u_host.send(4'h1, 1'b1);
        u_host.send(4'h2, 1'b0);
        u_host.send(4'h3, 1'b1);
        u_host.send(4'hF, 1'b1);
        repeat (20) @(negedge clk);
        chk("abort strobes", 0, n_stb);
        chk("abort drive", 0, n_oe);
        run(4'h5, 28'h1234567, 8'h5A, 4'h0, 1);
    endtask
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        s_array();
        s_regs();
        s_other();
        s_size();
        s_ids();
        s_abort();
        print_verdict();
    end
    initial begin
        #20000;
        n_mismatch++;
        print_verdict();
    end
endmodule
